//--- logic/elis_cfg.svh
`ifndef ELIS_CFG_SVH
`define ELIS_CFG_SVH
`define ELIS_OFS_EVT_EN 8'h34
`define ELIS_OFS_EVT_FLAGS 8'h3b
`define ELIS_OFS_CNT_HI 8'h3c
`define ELIS_OFS_CNT_LO 8'h3d
`define ELIS_OFS_PEND_LINE 8'h3f
`define ELIS_OFS_PEND_FRM 8'h40
`define ELIS_OFS_PEND_LINK 8'h41
`define ELIS_BIT_TEMPLATE 6
`define ELIS_BIT_TX_JA 5
`define ELIS_BIT_RX_JA 4
`define ELIS_BIT_ZERO_RUN 2
`define ELIS_BIT_CODE_VIOL 1
`define ELIS_BIT_CNT_OVF 0
`define ELIS_EVT_MASK 8'h77
`define ELIS_FRM_MASK 8'h3f
`define ELIS_LINK_MASK 8'hff
`define ELIS_DAC_LIMIT 8'sd63
`define ELIS_RST_BYTE 8'h00
`define ELIS_RST_CNT 16'h0000
`endif

//--- logic/elis_pkg.sv
package elis_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} elis_bus_t;
	typedef struct packed {
		logic template_overflow;
		logic tx_jitter_fifo;
		logic rx_jitter_fifo;
		logic zero_run_error;
		logic code_violation;
	} elis_evt_t;
	typedef struct packed {
		logic alarm;
		logic perf_monitor;
		logic pattern_gen;
		logic rx_signaling_buf;
		logic frame_gen;
		logic frame_proc;
	} elis_frm_t;
	typedef struct packed {
		logic [2:0] link_tx;
		logic [2:0] link_rx;
		logic elastic_buffer;
		logic system_if;
	} elis_link_t;
endpackage

//--- logic/elis_top.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "elis_cfg.svh"
// Function
// - set template overflow flag when multi-UI template sum exceeds plus or minus 63
// - set tx jitter FIFO flag, bit 5, on overflow or underflow
// - set rx jitter FIFO flag, bit 4, on overflow or underflow
// - set zero-run error flag, bit 2, on excessive zero error
// - set code violation flag, bit 1, on bipolar or HDB3 violation
// - set counter overflow flag, bit 0, when 16-bit zero-error counter overflows
// - flags stay set until host writes 1; writing 0 leaves them
// - counter readable as upper byte at 3C and lower byte at 3D
// - line-side pending bit at 3F while any line-side block interrupt pends
// - framing block pending bits readable at 40
// - link tx pending in bits 7..5, rx in 4..2, of 41
// - bit 1 of 41 shows elastic buffer pending
// - bit 0 of 41 shows system interface pending
// - flag drives interrupt only when its enable bit at 34 is set
module elis_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire elis_pkg::elis_bus_t bus,
	output logic [7:0] rdata,
	input wire elis_pkg::elis_evt_t evt,
	input wire logic template_multi_ui,
	input wire logic signed [9:0] template_sum,
	input wire logic template_sum_valid,
	input wire logic zero_error_inc,
	input wire logic line_block_irq,
	input wire elis_pkg::elis_frm_t frm_irq,
	input wire elis_pkg::elis_link_t link_irq,
	output logic irq
);
	logic rst_s1_r;
	logic rst_s2_r;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] enable_r;
	logic [15:0] count_r;
	logic [7:0] pend_line_r;
	logic [7:0] pend_frm_r;
	logic [7:0] pend_link_r;
	logic [7:0] rdata_nxt;
	logic irq_nxt;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	wire srst_n = rst_s2_r;
	wire wr_flags = bus.wr && (bus.addr == `ELIS_OFS_EVT_FLAGS);
	wire wr_enable = bus.wr && (bus.addr == `ELIS_OFS_EVT_EN);
	// a template sum outside the converter range is only reported when several UIs are combined
	wire tmpl_over = template_sum_valid && template_multi_ui &&
		((template_sum > 10'sd63) || (template_sum < -10'sd63));
	wire cnt_wrap = zero_error_inc && (count_r == 16'hffff);
	wire [15:0] count_nxt = zero_error_inc ? count_r + 16'h0001 : count_r;
	wire [7:0] evt_set = {1'b0, tmpl_over,
		evt.tx_jitter_fifo,
		evt.rx_jitter_fifo,
		1'b0,
		evt.zero_run_error,
		evt.code_violation,
		cnt_wrap};
	wire [7:0] clr_mask = wr_flags ? bus.wdata : 8'h00;
	// set wins over a simultaneous clear so no event is lost
	assign flags_nxt = ((flags_r & ~clr_mask) | evt_set) & `ELIS_EVT_MASK;
	// the pin follows the enable written in the same cycle, so it never lags a disable
	wire [7:0] enable_nxt = wr_enable ? (bus.wdata & `ELIS_EVT_MASK) : enable_r;
	assign irq_nxt = |(flags_nxt & enable_nxt);
	wire [7:0] pend_line_nxt = {7'h00, line_block_irq};
	wire [7:0] pend_frm_nxt = {2'b00, frm_irq} & `ELIS_FRM_MASK;
	wire [7:0] pend_link_nxt = link_irq;

	always_comb begin
		case (bus.addr)
			`ELIS_OFS_EVT_EN: rdata_nxt = enable_r;
			`ELIS_OFS_EVT_FLAGS: rdata_nxt = flags_r;
			`ELIS_OFS_CNT_HI: rdata_nxt = count_r[15:8];
			`ELIS_OFS_CNT_LO: rdata_nxt = count_r[7:0];
			`ELIS_OFS_PEND_LINE: rdata_nxt = pend_line_r;
			`ELIS_OFS_PEND_FRM: rdata_nxt = pend_frm_r;
			`ELIS_OFS_PEND_LINK: rdata_nxt = pend_link_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= `ELIS_RST_BYTE;
			enable_r <= `ELIS_RST_BYTE;
			count_r <= `ELIS_RST_CNT;
			pend_line_r <= `ELIS_RST_BYTE;
			pend_frm_r <= `ELIS_RST_BYTE;
			pend_link_r <= `ELIS_RST_BYTE;
			rdata <= `ELIS_RST_BYTE;
			irq <= 1'b0;
		end else if (!srst_n) begin
			flags_r <= `ELIS_RST_BYTE;
			enable_r <= `ELIS_RST_BYTE;
			count_r <= `ELIS_RST_CNT;
			pend_line_r <= `ELIS_RST_BYTE;
			pend_frm_r <= `ELIS_RST_BYTE;
			pend_link_r <= `ELIS_RST_BYTE;
			rdata <= `ELIS_RST_BYTE;
			irq <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			enable_r <= enable_nxt;
			count_r <= count_nxt;
			pend_line_r <= pend_line_nxt;
			pend_frm_r <= pend_frm_nxt;
			pend_link_r <= pend_link_nxt;
			rdata <= bus.rd ? rdata_nxt : 8'h00;
			irq <= irq_nxt;
		end
	end

	chk_flag_sticky: assert property (@(posedge mclk) disable iff (!srst_n)
		(flags_r[`ELIS_BIT_TX_JA] && !wr_flags) |=> flags_r[`ELIS_BIT_TX_JA])
		else $error("flag dropped without clear");
	chk_flag_clear_one: assert property (@(posedge mclk) disable iff (!srst_n)
		(wr_flags && bus.wdata[`ELIS_BIT_CODE_VIOL] && !evt.code_violation) |=> !flags_r[`ELIS_BIT_CODE_VIOL])
		else $error("write one did not clear flag");
	chk_tx_ja_set: assert property (@(posedge mclk) disable iff (!srst_n)
		evt.tx_jitter_fifo |=> flags_r[5]) else $error("tx fifo flag not set");
	chk_rx_ja_set: assert property (@(posedge mclk) disable iff (!srst_n)
		evt.rx_jitter_fifo |=> flags_r[4]) else $error("rx fifo flag not set");
	chk_zero_run_set: assert property (@(posedge mclk) disable iff (!srst_n)
		evt.zero_run_error |=> flags_r[2]) else $error("zero run flag not set");
	chk_code_viol_set: assert property (@(posedge mclk) disable iff (!srst_n)
		evt.code_violation |=> flags_r[1]) else $error("code violation flag not set");
	chk_cnt_wrap_set: assert property (@(posedge mclk) disable iff (!srst_n)
		(zero_error_inc && count_r == 16'hffff) |=> (flags_r[0] && count_r == 16'h0000))
		else $error("counter overflow not flagged");
	chk_template_set: assert property (@(posedge mclk) disable iff (!srst_n)
		(template_sum_valid && template_multi_ui && template_sum == 10'sd64) |=> flags_r[6])
		else $error("template overflow not flagged");
	chk_irq_gate: assert property (@(posedge mclk) disable iff (!srst_n)
		##1 (irq == |(flags_r & enable_r))) else $error("interrupt not gated by enable");
	chk_irq_release: assert property (@(posedge mclk) disable iff (!srst_n)
		((flags_r & enable_r) == 8'h00) |-> !irq) else $error("interrupt held with no enabled flag");
	chk_count_read: assert property (@(posedge mclk) disable iff (!srst_n)
		(bus.rd && bus.addr == `ELIS_OFS_CNT_LO) |=> (rdata == $past(count_r[7:0])))
		else $error("counter low byte read wrong");
	chk_link_pend: assert property (@(posedge mclk) disable iff (!srst_n)
		1'b1 |=> (pend_link_r == $past(link_irq))) else $error("link pending bits wrong");
endmodule

//--- verif/elis_host.sv
`timescale 1ns/100ps
// host side of the register port; strobes last one cycle and read data is taken in the cycle after
module elis_host (
	input wire logic mclk,
	input wire logic [7:0] rdata,
	output elis_pkg::elis_bus_t bus
);
	initial bus = '0;
	// a write of 1 clears a flag, a write of 0 leaves it
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '0;
		#1 v = rdata;
	endtask
endmodule

//--- verif/elis_top_test.sv
`timescale 1ns/100ps
module elis_top_test;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] rdata, d;
	logic irq, tmu = 1'b0, tsv = 1'b0, zinc = 1'b0, lbi = 1'b0;
	logic signed [9:0] tsum = 10'sh000;
	elis_pkg::elis_bus_t bus;
	elis_pkg::elis_evt_t evt = '0;
	elis_pkg::elis_frm_t frm = '0;
	elis_pkg::elis_link_t lnk = '0;
	logic [7:0] ofs [6] = '{8'h3b, 8'h3c, 8'h3d, 8'h3f, 8'h40, 8'h41};
	int miscompares = 0;
	int checks = 0;
	always #10 mclk = ~mclk;
	elis_host elis_host_i (.mclk(mclk), .rdata(rdata), .bus(bus));
	elis_top elis_top_i (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .evt(evt), .template_multi_ui(tmu),
		.template_sum(tsum), .template_sum_valid(tsv), .zero_error_inc(zinc), .line_block_irq(lbi),
		.frm_irq(frm), .link_irq(lnk), .irq(irq));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		elis_host_i.rd(a, d);
		chk(d, e);
	endtask
	task automatic ev(input elis_pkg::elis_evt_t e);
		@(posedge mclk);
		evt <= e;
		@(posedge mclk);
		evt <= '0;
	endtask
	task automatic tp(input logic m, input logic signed [9:0] s);
		@(posedge mclk);
		tmu <= m;
		tsum <= s;
		tsv <= 1'b1;
		@(posedge mclk);
		tsv <= 1'b0;
	endtask
	// held high, the increment counts once per edge
	task automatic inc(input int n);
		@(posedge mclk);
		zinc <= 1'b1;
		repeat (n) @(posedge mclk);
		zinc <= 1'b0;
	endtask
	task automatic finish_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// the counter wrap alone takes 65536 cycles
	initial begin
		repeat (80000) @(posedge mclk);
		miscompares++;
		finish_test;
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		foreach (ofs[i]) rc(ofs[i], 8'h00);
		elis_host_i.wr(8'h34, 8'h77);
		rc(8'h34, 8'h77);
		chk({7'h00, irq}, 8'h00);
		tp(1'b1, 10'sd63);
		tp(1'b0, 10'sd100);
		rc(8'h3b, 8'h00);
		tp(1'b1, -10'sd64);
		rc(8'h3b, 8'h40);
		ev(5'b01000);
		rc(8'h3b, 8'h60);
		ev(5'b00100);
		rc(8'h3b, 8'h70);
		ev(5'b00010);
		rc(8'h3b, 8'h74);
		ev(5'b00001);
		rc(8'h3b, 8'h76);
		chk({7'h00, irq}, 8'h01);
		elis_host_i.wr(8'h3b, 8'h00);
		rc(8'h3b, 8'h76);
		elis_host_i.wr(8'h3b, 8'h02);
		rc(8'h3b, 8'h74);
		elis_host_i.wr(8'h34, 8'h00);
		rc(8'h3b, 8'h74);
		chk({7'h00, irq}, 8'h00);
		elis_host_i.wr(8'h34, 8'h77);
		elis_host_i.wr(8'h3b, 8'h74);
		rc(8'h3b, 8'h00);
		chk({7'h00, irq}, 8'h00);
		elis_host_i.wr(8'h3c, 8'hff);
		inc(258);
		rc(8'h3c, 8'h01);
		rc(8'h3d, 8'h02);
		inc(65278);
		rc(8'h3d, 8'h00);
		rc(8'h3b, 8'h01);
		chk({7'h00, irq}, 8'h01);
		lbi <= 1'b1;
		frm <= 6'h2a;
		lnk <= 8'ha5;
		rc(8'h3f, 8'h01);
		rc(8'h40, 8'h2a);
		rc(8'h41, 8'ha5);
		rc(8'h50, 8'h00);
		finish_test;
	end
endmodule
